// File: pwm_timer.v
// Purpose: 8-bit timer with phase-correct PWM, two compare channels, async clocking
// Assumes: Registers over APB; oscillator input sampled on core_clk_in (40 MHz)
// Notes: Non phase-correct modes count up and wrap only
//
// How it works
// - Waveform mode 1 or 5 selects phase-correct operation.
// - Counter runs up BOTTOM to TOP, then down to BOTTOM.
// - TOP is 0xff in mode 1, compare value A in mode 5.
// - Counter shows TOP for one tick, then counts down.
// - Overflow flag sets on reaching BOTTOM; enabled flag raises interrupt.
// - Non-inverting clears on up match, sets on down match; inverting opposite.
// - Output mode 2 is non-inverted, 3 inverted.
// - Compare at BOTTOM gives constant low, at MAX constant high (non-inverted).
// - At BOTTOM output takes up-match level when leaving MAX or started above.
// - Sync tick enables the core clock; async uses oscillator edges instead.
// - Async writes go to a holding register, moved after two oscillator edges.
// - Five independent holding registers: control A, control B, counter, compare A, compare B.
// - Busy flag per register set by write, cleared after transfer.
// - Compare matching is off while counter or compare write pending.
// - Sleep wake-up, async mode only, starts on the timer tick after the event.
// - Counter reads use a shadow refreshed per oscillator edge in async mode, every core cycle in sync mode, frozen in sleep.
// - Async flags reach the core after a fixed delay of three core cycles.
// - Compare outputs change one core cycle after the timer tick, no extra sync.
// - Oscillator stops in the two deepest sleeps; contents then invalid.
// - Clock source defaults to core; async select moves to oscillator pin.
`timescale 1ns/1ps
`include "pwm_timer_defs.vh"
module pwm_timer (
    // Clock and reset
    input wire core_clk_in,
    input wire rstn_in,
    // APB slave
    input wire psel_in,
    input wire penable_in,
    input wire pwrite_in,
    input wire [7:0] paddr_in,
    input wire [31:0] pwdata_in,
    output reg [31:0] prdata_out,
    output reg pready_out,
    output reg pslverr_out,
    // Oscillator and power state
    input wire osc_clock_input_in,
    input wire sleep_in,
    input wire deep_sleep_in,
    // Timer outputs
    output reg compare_output_a_out,
    output reg compare_output_b_out,
    output reg irq_out,
    output reg wake_out,
    output reg osc_pins_detached_out
);
    // Software visible state
    reg [7:0] ctrl_a;
    reg [7:0] ctrl_b;
    reg [7:0] counter_value;
    reg [7:0] compare_value_a;
    reg [7:0] compare_value_b;
    reg [2:0] irq_mask;
    reg [2:0] flags;
    reg async_clock_select;
    reg [7:0] shadow;
    // Timer internals
    reg dir_up;
    reg [2:0] presc;
    reg tick_d;
    reg [2:0] evt_d1;
    reg [2:0] evt_d2;
    reg [2:0] evt_d3;
    reg wake_pend;
    reg [2:0] next_flags;
    reg [7:0] next_cnt;
    reg next_dir;
    reg [31:0] rdata;

    wire osc_rise;
    wire osc_tick;
    wire presc_tick;
    wire tick;
    wire [2:0] waveform_mode_field;
    wire pc_mode;
    wire [7:0] top;
    wire at_bottom;
    wire ovf_evt;
    wire [1:0] cmp_evt;
    wire [2:0] evt;
    wire [2:0] set_vec;
    wire [1:0] oc_q;
    wire [`NUM_HOLD-1:0] pend_bus;
    wire [`NUM_HOLD-1:0] commit;
    wire [8*`NUM_HOLD-1:0] hold_bus;
    wire match_en;
    wire wr_en;
    wire rd_en;
    wire addr_ok;
    wire cnt_load;
    wire [7:0] cnt_load_val;

    edge_sync u_osc_sync (
        .core_clk_in(core_clk_in),
        .rstn_in(rstn_in),
        .level_in(osc_clock_input_in),
        .rise_out(osc_rise)
    );

    // Bus phases: the access completes on its second cycle
    assign wr_en = psel_in & penable_in & pready_out & pwrite_in;
    assign rd_en = psel_in & penable_in & ~pready_out & ~pwrite_in;
    assign addr_ok = (paddr_in == `OFF_CTLA) | (paddr_in == `OFF_CTLB) | (paddr_in == `OFF_CNT) |
                     (paddr_in == `OFF_OCRA) | (paddr_in == `OFF_OCRB) | (paddr_in == `OFF_MASK) |
                     (paddr_in == `OFF_FLAG) | (paddr_in == `OFF_STAT);

    // Oscillator ticks vanish in the two deepest sleeps
    assign osc_tick = osc_rise & ~deep_sleep_in;
    assign presc_tick = (ctrl_b[`CS_FIELD] == `CS_DIRECT) |
                        ((ctrl_b[`CS_FIELD] != `CS_STOP) & (presc == `PRESC_LAST));
    // One clock only: the tick is an enable, never a clock
    assign tick = async_clock_select ? osc_tick : presc_tick;

    assign waveform_mode_field = {ctrl_b[`WGM_HI], ctrl_a[`WGM_LO]};
    assign pc_mode = (waveform_mode_field == `WGM_PC_FIXED) |
                     (waveform_mode_field == `WGM_PC_VAR);
    assign top = (waveform_mode_field == `WGM_PC_VAR) ? compare_value_a : `TOP_FIXED;
    assign at_bottom = pc_mode & (counter_value == `BOTTOM);

    // A pending counter or compare transfer blocks compare matches
    assign match_en = ~(pend_bus[`IDX_CNT] | pend_bus[`IDX_OCRA] | pend_bus[`IDX_OCRB]);

    // Holding registers, one per asynchronously written register
    genvar i;
    generate
        for (i = 0; i < `NUM_HOLD; i = i + 1) begin : g_hold
            localparam [7:0] OFFS = (i == `IDX_CNT) ? `OFF_CNT : (i == `IDX_OCRA) ? `OFF_OCRA :
                                    (i == `IDX_OCRB) ? `OFF_OCRB : (i == `IDX_CTLA) ? `OFF_CTLA : `OFF_CTLB;
            reg [7:0] hold;
            reg pend;
            reg [1:0] edges;
            wire hit;
            assign hit = wr_en & (paddr_in == OFFS) & async_clock_select;
            always @(posedge core_clk_in) begin
                if (!rstn_in) begin
                    hold <= `RESET_BYTE;
                    pend <= 1'b0;
                    edges <= 2'h0;
                end else if (hit) begin
                    hold <= pwdata_in[7:0];
                    pend <= 1'b1;
                    edges <= 2'h0;
                end else if (pend & osc_tick) begin
                    if (edges == `XFER_EDGES - 2'h1) begin
                        pend <= 1'b0;
                    end else begin
                        edges <= edges + 2'h1;
                    end
                end
            end
            // Transfer lands on the second oscillator edge after the write
            assign commit[i] = pend & osc_tick & (edges == `XFER_EDGES - 2'h1);
            assign pend_bus[i] = pend;
            assign hold_bus[8*i+7:8*i] = hold;
        end
    endgenerate

    // Direct write in sync mode, transfer from the holding register in async mode
    assign cnt_load = (wr_en & (paddr_in == `OFF_CNT) & ~async_clock_select) | commit[`IDX_CNT];
    assign cnt_load_val = commit[`IDX_CNT] ? hold_bus[8*`IDX_CNT+7:8*`IDX_CNT] : pwdata_in[7:0];

    // Counter sequencing
    always @* begin
        next_cnt = counter_value;
        next_dir = dir_up;
        if (pc_mode) begin
            if (dir_up) begin
                if (counter_value >= top) begin
                    next_cnt = counter_value - 8'h01;
                    next_dir = 1'b0;
                end else begin
                    next_cnt = counter_value + 8'h01;
                end
            end else begin
                if (counter_value == `BOTTOM) begin
                    next_cnt = counter_value + 8'h01;
                    next_dir = 1'b1;
                end else begin
                    next_cnt = counter_value - 8'h01;
                end
            end
        end else begin
            next_cnt = counter_value + 8'h01;
            next_dir = 1'b1;
        end
    end

    // Overflow event when the counter arrives at BOTTOM
    assign ovf_evt = tick & ~cnt_load & (next_cnt == `BOTTOM) &
                     (pc_mode ? ~dir_up : (counter_value == `MAX_VAL));

    always @(posedge core_clk_in) begin
        if (!rstn_in) begin
            counter_value <= `RESET_BYTE;
            dir_up <= 1'b1;
            presc <= 3'h0;
        end else begin
            presc <= (ctrl_b[`CS_FIELD] == `CS_STOP) ? 3'h0 : presc + 3'h1;
            if (cnt_load) begin
                counter_value <= cnt_load_val;
            end else if (tick) begin
                counter_value <= next_cnt;
                dir_up <= next_dir;
            end
        end
    end

    // Compare channels
    generate
        for (i = 0; i < 2; i = i + 1) begin : g_cmp
            wire [7:0] ocr;
            wire [1:0] compare_output_mode;
            wire match;
            wire up_level;
            reg oc;
            reg prev_max;
            reg start_above;
            assign ocr = (i == 0) ? compare_value_a : compare_value_b;
            assign compare_output_mode = (i == 0) ? ctrl_a[7:6] : ctrl_a[5:4];
            assign match = tick & match_en & ~cnt_load & (counter_value == ocr);
            // Up-match level: low for mode 2, high for mode 3
            assign up_level = compare_output_mode[0];
            always @(posedge core_clk_in) begin
                if (!rstn_in) begin
                    oc <= 1'b0;
                    prev_max <= 1'b0;
                    start_above <= 1'b0;
                end else begin
                    if (cnt_load) begin
                        start_above <= (cnt_load_val > ocr);
                    end else if (tick & at_bottom) begin
                        start_above <= 1'b0;
                    end
                    if (tick & at_bottom) begin
                        prev_max <= (ocr == `MAX_VAL);
                    end
                    if (pc_mode & compare_output_mode[1]) begin
                        // BOTTOM counts as an up match, TOP as a down match
                        if (tick & at_bottom & ((ocr == `BOTTOM) | start_above |
                            (prev_max & (ocr != `MAX_VAL)))) begin
                            oc <= up_level;
                        end else if (match & (counter_value == top)) begin
                            oc <= ~up_level;
                        end else if (match) begin
                            oc <= dir_up ? up_level : ~up_level;
                        end
                    end
                end
            end
            assign cmp_evt[i] = match;
            assign oc_q[i] = oc;
        end
    endgenerate

    assign evt = {cmp_evt[1], cmp_evt[0], ovf_evt};
    // Async events cross with a fixed three-cycle delay
    assign set_vec = async_clock_select ? evt_d3 : evt;

    always @* begin
        next_flags = flags;
        if (wr_en & (paddr_in == `OFF_FLAG)) begin
            next_flags = flags & ~pwdata_in[2:0];
        end
        // A set in the clearing cycle is kept
        next_flags = next_flags | set_vec;
    end

    // Register file, flags, shadow and outputs
    always @(posedge core_clk_in) begin
        if (!rstn_in) begin
            ctrl_a <= `RESET_BYTE;
            ctrl_b <= `RESET_BYTE;
            compare_value_a <= `RESET_BYTE;
            compare_value_b <= `RESET_BYTE;
            irq_mask <= 3'h0;
            flags <= 3'h0;
            async_clock_select <= 1'b0;
            shadow <= `RESET_BYTE;
            tick_d <= 1'b0;
            evt_d1 <= 3'h0;
            evt_d2 <= 3'h0;
            evt_d3 <= 3'h0;
            wake_pend <= 1'b0;
            wake_out <= 1'b0;
            irq_out <= 1'b0;
            compare_output_a_out <= 1'b0;
            compare_output_b_out <= 1'b0;
            osc_pins_detached_out <= 1'b0;
        end else begin
            if (commit[`IDX_CTLA]) begin
                ctrl_a <= hold_bus[8*`IDX_CTLA+7:8*`IDX_CTLA];
            end else if (wr_en & (paddr_in == `OFF_CTLA) & ~async_clock_select) begin
                ctrl_a <= pwdata_in[7:0];
            end
            if (commit[`IDX_CTLB]) begin
                ctrl_b <= hold_bus[8*`IDX_CTLB+7:8*`IDX_CTLB];
            end else if (wr_en & (paddr_in == `OFF_CTLB) & ~async_clock_select) begin
                ctrl_b <= pwdata_in[7:0];
            end
            if (commit[`IDX_OCRA]) begin
                compare_value_a <= hold_bus[8*`IDX_OCRA+7:8*`IDX_OCRA];
            end else if (wr_en & (paddr_in == `OFF_OCRA) & ~async_clock_select) begin
                compare_value_a <= pwdata_in[7:0];
            end
            if (commit[`IDX_OCRB]) begin
                compare_value_b <= hold_bus[8*`IDX_OCRB+7:8*`IDX_OCRB];
            end else if (wr_en & (paddr_in == `OFF_OCRB) & ~async_clock_select) begin
                compare_value_b <= pwdata_in[7:0];
            end
            if (wr_en & (paddr_in == `OFF_MASK)) begin
                irq_mask <= pwdata_in[2:0];
            end
            if (wr_en & (paddr_in == `OFF_STAT)) begin
                async_clock_select <= pwdata_in[`STAT_ASYNC];
            end
            flags <= next_flags;
            evt_d1 <= evt;
            evt_d2 <= evt_d1;
            evt_d3 <= evt_d2;
            // Shadow follows one cycle behind each oscillator tick in async mode, every cycle in sync mode, and freezes in sleep
            tick_d <= osc_tick;
            if (~sleep_in & (~async_clock_select | tick_d)) begin
                shadow <= counter_value;
            end
            // Wake request waits for the next timer tick after the event
            if (~sleep_in) begin
                wake_pend <= 1'b0;
                wake_out <= 1'b0;
            end else begin
                if (async_clock_select & |(evt & irq_mask)) begin
                    wake_pend <= 1'b1;
                end
                if (wake_pend & tick) begin
                    wake_out <= 1'b1;
                end
            end
            irq_out <= |(next_flags & irq_mask);
            // Pins are registered from the tick-domain state, one core cycle behind it
            compare_output_a_out <= oc_q[0];
            compare_output_b_out <= oc_q[1];
            osc_pins_detached_out <= async_clock_select;
        end
    end

    // Read mux
    always @* begin
        rdata = 32'h0000_0000;
        case (paddr_in)
            `OFF_CTLA: rdata[7:0] = ctrl_a;
            `OFF_CTLB: rdata[7:0] = ctrl_b;
            `OFF_CNT: rdata[7:0] = shadow;
            `OFF_OCRA: rdata[7:0] = compare_value_a;
            `OFF_OCRB: rdata[7:0] = compare_value_b;
            `OFF_MASK: rdata[2:0] = irq_mask;
            `OFF_FLAG: rdata[2:0] = flags;
            `OFF_STAT: rdata[5:0] = {async_clock_select, pend_bus};
            default: rdata = 32'h0000_0000;
        endcase
    end

    // APB answer: pready on the second access cycle
    always @(posedge core_clk_in) begin
        if (!rstn_in) begin
            prdata_out <= 32'h0000_0000;
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
        end else if (psel_in & penable_in & ~pready_out) begin
            pready_out <= 1'b1;
            pslverr_out <= ~addr_ok;
            prdata_out <= rd_en ? rdata : 32'h0000_0000;
        end else begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
        end
    end
endmodule // pwm_timer

// File: pwm_timer_defs.vh
// Purpose: Shared constants for the dual-slope PWM timer
// Assumes: APB slave, 32-bit data, word aligned offsets
// Notes: Definitions only
`ifndef PWM_TIMER_DEFS_VH
`define PWM_TIMER_DEFS_VH

// Register byte offsets
`define OFF_CTLA 8'h00
`define OFF_CTLB 8'h04
`define OFF_CNT 8'h08
`define OFF_OCRA 8'h0c
`define OFF_OCRB 8'h10
`define OFF_MASK 8'h14
`define OFF_FLAG 8'h18
`define OFF_STAT 8'h1c

// Temporary holding entry indices
`define IDX_CNT 0
`define IDX_OCRA 1
`define IDX_OCRB 2
`define IDX_CTLA 3
`define IDX_CTLB 4
`define NUM_HOLD 5

// Field positions
`define WGM_LO 1:0
`define WGM_HI 3
`define CS_FIELD 2:0
`define STAT_ASYNC 5
`define FLAG_OVF 0
`define FLAG_CMPA 1
`define FLAG_CMPB 2

// Encodings and values
`define WGM_PC_FIXED 3'h1
`define WGM_PC_VAR 3'h5
`define COM_NONINV 2'h2
`define COM_INV 2'h3
`define CS_STOP 3'h0
`define CS_DIRECT 3'h1
`define TOP_FIXED 8'hff
`define BOTTOM 8'h00
`define MAX_VAL 8'hff
`define RESET_BYTE 8'h00

// Timing counts
`define XFER_EDGES 2'h2
`define PRESC_LAST 3'h7

`endif

// File: edge_sync.v
// Purpose: Bring the oscillator level into the core clock and flag its rising edges
// Assumes: Oscillator much slower than core clock
// Notes: First stage feeds only the second stage
`timescale 1ns/1ps
module edge_sync (
    // Clock and reset
    input wire core_clk_in,
    input wire rstn_in,
    // Level and edge
    input wire level_in,
    output wire rise_out
);
    reg meta;
    reg stable;
    reg stable_d;

    always @(posedge core_clk_in) begin
        if (!rstn_in) begin
            meta <= 1'b0;
            stable <= 1'b0;
            stable_d <= 1'b0;
        end else begin
            meta <= level_in;
            stable <= meta;
            stable_d <= stable;
        end
    end

    assign rise_out = stable & ~stable_d;
endmodule // edge_sync

// File: pwm_timer_asserts.sv
// Purpose: Port checks for the dual-slope PWM timer
// Assumes: One clock, synchronous active-low reset
// Notes: APB answers after exactly one wait state
`timescale 1ns/1ps
`include "pwm_timer_defs.vh"
module pwm_timer_asserts (
    // Clock and reset
    input wire core_clk_in,
    input wire rstn_in,
    // APB
    input wire psel_in,
    input wire penable_in,
    input wire pwrite_in,
    input wire [7:0] paddr_in,
    input wire [31:0] pwdata_in,
    input wire [31:0] prdata_out,
    input wire pready_out,
    input wire pslverr_out,
    // Power and status
    input wire sleep_in,
    input wire irq_out,
    input wire wake_out,
    input wire osc_pins_detached_out
);
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!rstn_in);

    property p_ready_pulse;
        pready_out |=> !pready_out;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready held past one cycle");

    property p_ready_place;
        pready_out |-> psel_in && penable_in && $past(psel_in && penable_in);
    endproperty
    a_ready_place: assert property (p_ready_place) else $error("ready outside second access cycle");

    property p_ready_wait;
        psel_in && penable_in && !pready_out |=> pready_out;
    endproperty
    a_ready_wait: assert property (p_ready_wait) else $error("ready missing after one wait state");

    property p_err_ready;
        pslverr_out |-> pready_out;
    endproperty
    a_err_ready: assert property (p_err_ready) else $error("error without ready");

    property p_err_zero;
        pslverr_out && !pwrite_in |-> prdata_out == 32'h0;
    endproperty
    a_err_zero: assert property (p_err_zero) else $error("refused read returned data");

    property p_upper_zero;
        pready_out && !pwrite_in |-> prdata_out[31:8] == 24'h0;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper read bits not zero");

    property p_detach;
        psel_in && penable_in && pready_out && pwrite_in && paddr_in == `OFF_STAT
            |-> ##2 osc_pins_detached_out == $past(pwdata_in[`STAT_ASYNC], 2);
    endproperty
    a_detach: assert property (p_detach) else $error("pin detach does not follow select");

    property p_wake_drop;
        !sleep_in |=> !wake_out;
    endproperty
    a_wake_drop: assert property (p_wake_drop) else $error("wake stays high while awake");

    property p_reset_quiet;
        $rose(rstn_in) |-> !irq_out && !wake_out && !pready_out && !osc_pins_detached_out;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("output active after reset");

    c_write: cover property (psel_in && penable_in && pready_out && pwrite_in);
    c_refuse: cover property (pslverr_out);
    c_wake: cover property ($rose(wake_out));
    c_irq: cover property ($rose(irq_out));
endmodule // pwm_timer_asserts

bind pwm_timer pwm_timer_asserts u_asserts (
    .core_clk_in(core_clk_in),
    .rstn_in(rstn_in),
    .psel_in(psel_in),
    .penable_in(penable_in),
    .pwrite_in(pwrite_in),
    .paddr_in(paddr_in),
    .pwdata_in(pwdata_in),
    .prdata_out(prdata_out),
    .pready_out(pready_out),
    .pslverr_out(pslverr_out),
    .sleep_in(sleep_in),
    .irq_out(irq_out),
    .wake_out(wake_out),
    .osc_pins_detached_out(osc_pins_detached_out)
);

// File: async_timer_phase_correct_pwm_bench.sv
// Purpose: Self-checking bench for the dual-slope PWM timer
// Assumes: 40 MHz core clock, bench oscillator at 2.5 MHz
// Notes: Oscillator timing sections rely on its fixed 16 cycle period
`timescale 1ns/1ps
`include "pwm_timer_defs.vh"
module async_timer_phase_correct_pwm_bench;
    reg core_clk_in = 1'b0;
    reg rstn_in = 1'b0;
    reg psel_in = 1'b0;
    reg penable_in = 1'b0;
    reg pwrite_in = 1'b0;
    reg [7:0] paddr_in = 8'h00;
    reg [31:0] pwdata_in = 32'h0;
    reg osc_clock_input_in = 1'b0;
    reg sleep_in = 1'b0;
    reg deep_sleep_in = 1'b0;
    wire [31:0] prdata_out;
    wire pready_out, pslverr_out, compare_output_a_out, compare_output_b_out;
    wire irq_out, wake_out, osc_pins_detached_out;
    integer num_errors = 0;
    integer num_checks = 0;
    integer cyc = 0;
    integer h, p, t1;
    reg [31:0] r;
    reg e;
    reg [2:0] osc_div = 3'h0;

    pwm_timer u_dut (
        .core_clk_in(core_clk_in), .rstn_in(rstn_in), .psel_in(psel_in), .penable_in(penable_in),
        .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
        .pready_out(pready_out), .pslverr_out(pslverr_out), .osc_clock_input_in(osc_clock_input_in),
        .sleep_in(sleep_in), .deep_sleep_in(deep_sleep_in), .compare_output_a_out(compare_output_a_out),
        .compare_output_b_out(compare_output_b_out), .irq_out(irq_out), .wake_out(wake_out),
        .osc_pins_detached_out(osc_pins_detached_out)
    );

    always #12.5 core_clk_in = ~core_clk_in;
    // Oscillator at a sixteenth of the core clock, well inside the four-times limit
    always @(posedge core_clk_in) begin
        osc_div <= osc_div + 3'h1;
        if (osc_div == 3'h7) osc_clock_input_in <= ~osc_clock_input_in;
    end
    always @(posedge core_clk_in) cyc <= cyc + 1;

    task automatic summarize;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic fail(input string s);
        num_errors = num_errors + 1;
        $display("unexpected at %0t: %s", $time, s);
        summarize;
    endtask

    task automatic check(input [31:0] got, input [31:0] exp, input string s);
        num_checks = num_checks + 1;
        if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("unexpected at %0t: %s got %h want %h", $time, s, got, exp);
        end
    endtask

    task automatic apb(input w, input [7:0] a, input [31:0] d);
        integer k;
        k = 0;
        @(posedge core_clk_in);
        psel_in <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge core_clk_in);
        penable_in <= 1'b1;
        do begin
            @(posedge core_clk_in);
            k = k + 1;
        end while (pready_out !== 1'b1 && k < 20);
        r = prdata_out;
        e = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        if (k >= 20) fail("bus timeout");
    endtask

    task automatic wait_pin(input b, input v, output integer c);
        c = 0;
        while ((b ? compare_output_b_out : compare_output_a_out) !== v) begin
            @(posedge core_clk_in);
            c = c + 1;
            if (c > 3000) fail("pin stuck");
        end
    endtask

    task automatic measure(input b, output integer hi, output integer per);
        integer c;
        wait_pin(b, 1'b0, c);
        wait_pin(b, 1'b1, c);
        wait_pin(b, 1'b0, hi);
        wait_pin(b, 1'b1, c);
        per = hi + c;
    endtask

    task automatic wait_sig(input w);
        integer c;
        c = 0;
        while ((w ? wake_out : irq_out) !== 1'b1) begin
            @(posedge core_clk_in);
            c = c + 1;
            if (c > 12000) fail("event missing");
        end
    endtask

    // Lands after the core has seen the oscillator rise
    task automatic osc_mark;
        @(posedge osc_clock_input_in);
        repeat (6) @(posedge core_clk_in);
    endtask

    task automatic t_regs;
        integer i;
        for (i = 0; i < 8; i = i + 1) begin
            apb(1'b0, 8'(i * 4), 32'h0);
            check(r, 32'h0, "reset value");
        end
        apb(1'b0, 8'h20, 32'h0);
        check({r[30:0], e}, 32'h1, "unmapped read");
        apb(1'b1, 8'h24, 32'h5a);
        check(e, 1, "unmapped write");
        apb(1'b1, `OFF_OCRB, 32'h5a);
        apb(1'b0, `OFF_OCRB, 32'h0);
        check(r, 32'h5a, "compare readback");
        $display("test regs done");
    endtask

    task automatic t_pwm;
        apb(1'b1, `OFF_CTLB, 32'h00);
        apb(1'b1, `OFF_CNT, 32'h00);
        apb(1'b1, `OFF_OCRA, 32'h80);
        apb(1'b1, `OFF_OCRB, 32'h40);
        apb(1'b1, `OFF_CTLA, 32'hb1);
        apb(1'b1, `OFF_CTLB, 32'h01);
        measure(1'b0, h, p);
        check(p, 510, "fixed top period");
        check(h, 256, "non-inverted high time");
        measure(1'b1, h, p);
        check(h, 382, "inverted high time");
        $display("test pwm done");
    endtask

    task automatic t_vartop;
        apb(1'b1, `OFF_CTLB, 32'h00);
        apb(1'b1, `OFF_CNT, 32'h00);
        apb(1'b1, `OFF_OCRA, 32'h64);
        apb(1'b1, `OFF_CTLB, 32'h09);
        measure(1'b1, h, p);
        check(p, 200, "variable top period");
        check(h, 72, "variable top high time");
        $display("test vartop done");
    endtask

    task automatic t_extreme;
        integer i, c;
        apb(1'b1, `OFF_CTLB, 32'h01);
        for (i = 0; i < 4; i = i + 1) begin
            apb(1'b1, `OFF_OCRA, i[0] ? 32'hff : 32'h00);
            apb(1'b1, `OFF_CTLA, i[1] ? 32'hc1 : 32'h81);
            repeat (520) @(posedge core_clk_in);
            c = 0;
            repeat (520) begin
                @(posedge core_clk_in);
                if (compare_output_a_out !== (i[0] ^ i[1])) c = c + 1;
            end
            check(c, 0, "extreme compare level");
        end
        $display("test extreme done");
    endtask

    task automatic t_ovf;
        apb(1'b1, `OFF_FLAG, 32'h07);
        apb(1'b1, `OFF_MASK, 32'h01);
        wait_sig(1'b0);
        apb(1'b1, `OFF_FLAG, 32'h01);
        repeat (2) @(posedge core_clk_in);
        check(irq_out, 0, "interrupt after clear");
        wait_sig(1'b0);
        t1 = cyc;
        apb(1'b0, `OFF_FLAG, 32'h0);
        check(r[0], 1, "overflow flag");
        apb(1'b1, `OFF_FLAG, 32'h01);
        repeat (2) @(posedge core_clk_in);
        wait_sig(1'b0);
        check(cyc - t1, 510, "overflow spacing");
        apb(1'b1, `OFF_MASK, 32'h00);
        $display("test overflow done");
    endtask

    task automatic t_async;
        integer n;
        apb(1'b1, `OFF_MASK, 32'h00);
        apb(1'b1, `OFF_STAT, 32'h20);
        repeat (2) @(posedge core_clk_in);
        check(osc_pins_detached_out, 1, "pins detached");
        apb(1'b1, `OFF_CNT, 32'h00);
        apb(1'b1, `OFF_OCRB, 32'h40);
        n = 0;
        do begin
            apb(1'b0, `OFF_STAT, 32'h0);
            n = n + 1;
        end while (r !== 32'h20 && n < 50);
        check(r, 32'h20, "busy flags settle");
        osc_mark;
        apb(1'b1, `OFF_CTLB, 32'h01);
        apb(1'b1, `OFF_OCRA, 32'h80);
        osc_mark;
        apb(1'b0, `OFF_STAT, 32'h0);
        check(r, 32'h32, "busy after one edge");
        osc_mark;
        apb(1'b0, `OFF_STAT, 32'h0);
        check(r, 32'h20, "busy after two edges");
        apb(1'b1, `OFF_FLAG, 32'h07);
        apb(1'b1, `OFF_MASK, 32'h02);
        osc_mark;
        apb(1'b0, `OFF_CNT, 32'h0);
        t1 = r;
        apb(1'b0, `OFF_CNT, 32'h0);
        check(r, t1, "shadow steady within tick");
        sleep_in <= 1'b1;
        wait_sig(1'b1);
        osc_mark;
        sleep_in <= 1'b0;
        apb(1'b0, `OFF_CNT, 32'h0);
        check(r, t1, "shadow holds pre-sleep value");
        apb(1'b0, `OFF_FLAG, 32'h0);
        check(r[1], 1, "compare flag caused wake");
        deep_sleep_in <= 1'b1;
        apb(1'b0, `OFF_CNT, 32'h0);
        t1 = r;
        osc_mark;
        osc_mark;
        apb(1'b0, `OFF_CNT, 32'h0);
        check(r, t1, "counter frozen in deep sleep");
        deep_sleep_in <= 1'b0;
        $display("test async done");
    endtask

    initial begin
        repeat (12) @(posedge core_clk_in);
        rstn_in <= 1'b1;
        t_regs;
        t_pwm;
        t_vartop;
        t_extreme;
        t_ovf;
        t_async;
        summarize;
    end
endmodule // async_timer_phase_correct_pwm_bench
